// [sepc_pkg.sv]
/*
 Constants for the status, fault and phrase command interpreter.
 Assumes a 10 MHz system clock and a host on the serial command link.
*/
package sepc_pkg;
	// Opcodes of the serial command link
	localparam logic [7:0]  OP_ROM_INFO   = 8'hB4;
	localparam logic [7:0]  OP_FAULT_RD   = 8'hB8;
	localparam logic [7:0]  OP_BANK_MASK  = 8'hFE;
	localparam logic [7:0]  OP_PIN_SRC    = 8'hC0;
	localparam logic [7:0]  OP_PHRASE_W   = 8'hC4;
	localparam logic [7:0]  OP_FAULT_CLR  = 8'hFF;
	// Pin source byte fields
	localparam int          ARG_PIN_BIT   = 6;
	localparam int          ARG_SRC_HI    = 5;
	localparam int          ARG_SRC_LO    = 4;
	localparam int          ARG_MASK_HI   = 3;
	localparam int          CFG_W         = 6;
	localparam logic [1:0]  SRC_BUSY      = 2'h0;
	localparam logic [1:0]  SRC_READY     = 2'h1;
	localparam int          SRC_FAULT_BIT = 1;
	localparam logic [5:0]  PIN_A_RST     = 6'h11;
	localparam logic [5:0]  PIN_B_RST     = 6'h01;
	// Phrase byte fields
	localparam int          PHR_W         = 12;
	localparam int          PHR_HI_W      = 4;
	localparam int          CH_HI         = 5;
	localparam int          CH_LO         = 4;
	localparam int          CHANS         = 4;
	// Serial framing
	localparam logic [2:0]  BIT_LAST      = 3'h7;
	// Fault flags: bank 0 in [7:0], bank 1 in [15:8]
	localparam logic [15:0] FLAG_MASK     = 16'hF1FF;
	localparam logic [15:0] FAULT_EN_RST  = 16'h0000;
	localparam int          F_CMD         = 0;
	localparam int          F_TEMP        = 2;
	localparam int          F_WDT         = 5;
	localparam int          F_RSTC        = 6;
	localparam logic [7:0]  TEMP_LIMIT_C  = 8'h82;
	// Register map
	localparam logic [7:0]  ADDR_MAP_MASK = 8'hE3;
	localparam logic [7:0]  ADDR_ROM_INFO = 8'h00;
	localparam logic [7:0]  ADDR_FAULT_EN = 8'h04;
	localparam logic [7:0]  ADDR_FLAGS    = 8'h08;
	localparam logic [7:0]  ADDR_CLEAR    = 8'h0C;
	localparam logic [7:0]  ADDR_ROUTE    = 8'h10;
	localparam logic [7:0]  ADDR_PHR01    = 8'h14;
	localparam logic [7:0]  ADDR_PHR23    = 8'h18;
	localparam logic [7:0]  ADDR_CHAN     = 8'h1C;
	localparam logic [7:0]  ROM_INFO_RST  = 8'h00;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	typedef enum logic [2:0] {
		CMD_IDLE,
		CMD_PIN_ARG,
		CMD_PHR_HI,
		CMD_PHR_LO,
		CMD_READ
	} sepc_cmd_st_t;
endpackage

// [sepc_serial_port.sv]
/*
 Byte shifter for the serial command link, MSB first.
 Assumes the host changes data on the falling clock edge and the device
 samples on the rising one; link pins are asynchronous to clk_i.
*/
`timescale 1ns/10ps
module sepc_serial_port (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       sck_i,
	input  wire logic       cs_n_i,
	input  wire logic       si_i,
	input  wire logic       tx_load_i,
	input  wire logic [7:0] tx_byte_i,
	output logic      [7:0] rx_byte_o,
	output logic            rx_valid_o,
	output logic            idle_o,
	output logic            so_o,
	output logic            so_oe_o
);
	logic [2:0] sck_q;
	logic [2:0] cs_q;
	logic [1:0] si_q;
	logic [2:0] cnt_q;
	logic [7:0] rx_q;
	logic [7:0] tx_q;

	wire rise = sck_q[1] & ~sck_q[2];
	wire fall = ~sck_q[1] & sck_q[2];
	wire [7:0] rx_next = {rx_q[6:0], si_q[1]};

	assign idle_o = cs_q[1];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sck_q <= 3'h7;
			cs_q  <= 3'h7;
			si_q  <= 2'h0;
		end else begin
			sck_q <= {sck_q[1:0], sck_i};
			cs_q  <= {cs_q[1:0], cs_n_i};
			si_q  <= {si_q[0], si_i};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q      <= 3'h0;
			rx_q       <= 8'h00;
			tx_q       <= 8'h00;
			rx_byte_o  <= 8'h00;
			rx_valid_o <= 1'b0;
			so_o       <= 1'b0;
			so_oe_o    <= 1'b0;
		end else begin
			rx_valid_o <= 1'b0;
			if (cs_q[1]) begin
				// Deselect ends any partial byte
				cnt_q   <= 3'h0;
				so_o    <= 1'b0;
				so_oe_o <= 1'b0;
			end else begin
				if (rise) begin
					rx_q  <= rx_next;
					cnt_q <= cnt_q + 3'h1;
					if (cnt_q == sepc_pkg::BIT_LAST) begin
						rx_byte_o  <= rx_next;
						rx_valid_o <= 1'b1;
						so_oe_o    <= 1'b0;
					end
				end
				if (tx_load_i) begin
					tx_q    <= tx_byte_i;
					so_oe_o <= 1'b1;
				end else if (fall && so_oe_o) begin
					so_o <= tx_q[7];
					tx_q <= {tx_q[6:0], 1'b0};
				end
			end
		end
	end
endmodule

// [sepc_fault_flags.sv]
/*
 Sticky fault flags in two banks with per-flag enables.
 Assumes detector inputs are on clk_i; event inputs are one-cycle pulses.
*/
`timescale 1ns/10ps
module sepc_fault_flags (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        clear_i,
	input  wire logic [15:0] en_i,
	input  wire logic        cmd_error_i,
	input  wire logic        spk_open_i,
	input  wire logic [7:0]  die_temp_i,
	input  wire logic        spk_short_i,
	input  wire logic        flash_fault_i,
	input  wire logic        wdt_ovf_i,
	input  wire logic        rst_cnt_ovf_i,
	input  wire logic        osc_stop_i,
	input  wire logic        wave_mismatch_i,
	input  wire logic        bit_clk_fault_i,
	input  wire logic        frame_clk_fault_i,
	input  wire logic        audio_in_fault_i,
	input  wire logic        mix_count_fault_i,
	output logic      [15:0] flags_o,
	output logic             any_o
);
	logic wdt_seen_q;

	wire hot = die_temp_i >= sepc_pkg::TEMP_LIMIT_C;
	wire rst_ev = rst_cnt_ovf_i | (wdt_ovf_i & wdt_seen_q);
	wire [15:0] raw = {mix_count_fault_i, audio_in_fault_i, frame_clk_fault_i,
		bit_clk_fault_i, 3'h0, wave_mismatch_i, osc_stop_i, rst_ev, wdt_ovf_i,
		flash_fault_i, spk_short_i, hot, spk_open_i, cmd_error_i};
	// Disabled detectors never raise a flag
	wire [15:0] set_v = raw & en_i & sepc_pkg::FLAG_MASK;

	assign any_o = |flags_o;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wdt_seen_q <= 1'b0;
		end else if (wdt_ovf_i && en_i[sepc_pkg::F_WDT]) begin
			wdt_seen_q <= 1'b1;
		end
	end

	for (genvar i = 0; i < 16; i++) begin : g_flag
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				flags_o[i] <= 1'b0;
			end else begin
				// A persisting condition beats the clear
				flags_o[i] <= set_v[i] | (flags_o[i] & ~clear_i);
			end
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_hot;
		(hot && en_i[sepc_pkg::F_TEMP]) |=> flags_o[sepc_pkg::F_TEMP];
	endproperty
	a_hot: assert property (p_hot) else $error("hot die not flagged");

	property p_wdt2;
		(wdt_ovf_i && wdt_seen_q && en_i[sepc_pkg::F_RSTC])
			|=> flags_o[sepc_pkg::F_RSTC] &&
			(flags_o[sepc_pkg::F_WDT] || !$past(en_i[sepc_pkg::F_WDT]));
	endproperty
	a_wdt2: assert property (p_wdt2) else $error("second overflow lost");

	property p_clr;
		(clear_i && set_v == 16'h0000) |=> (flags_o == 16'h0000) ##1 (flags_o == $past(set_v));
	endproperty
	a_clr: assert property (p_clr) else $error("clear left flags");
endmodule

// [sepc_cmd_core.sv]
/*
 Command interpreter: ROM info and fault reads, status pin routing,
 wide phrase set, fault clear, plus an AXI4-Lite register slave.
 Assumes channel ready/busy and fault detectors run on clk_i.
*/
`timescale 1ns/10ps
module sepc_cmd_core (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        sck_i,
	input  wire logic        cs_n_i,
	input  wire logic        si_i,
	output logic             so_o,
	output logic             so_oe_o,
	input  wire logic [3:0]  chan_ready_n_i,
	input  wire logic [3:0]  chan_busy_n_i,
	input  wire logic        cmd_error_i,
	input  wire logic        spk_open_i,
	input  wire logic [7:0]  die_temp_i,
	input  wire logic        spk_short_i,
	input  wire logic        flash_fault_i,
	input  wire logic        wdt_ovf_i,
	input  wire logic        rst_cnt_ovf_i,
	input  wire logic        osc_stop_i,
	input  wire logic        wave_mismatch_i,
	input  wire logic        bit_clk_fault_i,
	input  wire logic        frame_clk_fault_i,
	input  wire logic        audio_in_fault_i,
	input  wire logic        mix_count_fault_i,
	output logic             state_pin_a_o,
	output logic             state_pin_b_o,
	output logic             fault_any_o,
	output logic [47:0]      phrase_number_o,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	sepc_pkg::sepc_cmd_st_t st_q;
	sepc_pkg::sepc_cmd_st_t st_d;
	logic [7:0]  rx_byte;
	logic        rx_valid;
	logic        link_idle;
	logic        tx_load_q;
	logic [7:0]  tx_byte_q;
	logic [7:0]  rom_info_q;
	logic [15:0] fault_en_q;
	logic [15:0] flags;
	logic        any_fault;
	logic [5:0]  pin_cfg_q [2];
	logic [1:0]  pin_q;
	logic [11:0] phrase_q [4];
	logic [1:0]  ch_q;
	logic [3:0]  hi_q;
	logic        wr_go_q;
	logic        rd_go_q;

	sepc_serial_port u_port (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.sck_i      (sck_i),
		.cs_n_i     (cs_n_i),
		.si_i       (si_i),
		.tx_load_i  (tx_load_q),
		.tx_byte_i  (tx_byte_q),
		.rx_byte_o  (rx_byte),
		.rx_valid_o (rx_valid),
		.idle_o     (link_idle),
		.so_o       (so_o),
		.so_oe_o    (so_oe_o)
	);

	// Opcode decode, only meaningful in the idle state
	wire at_op   = rx_valid && st_q == sepc_pkg::CMD_IDLE;
	wire is_rom  = rx_byte == sepc_pkg::OP_ROM_INFO;
	wire is_flt  = (rx_byte & sepc_pkg::OP_BANK_MASK) == sepc_pkg::OP_FAULT_RD;
	wire is_pin  = rx_byte == sepc_pkg::OP_PIN_SRC;
	wire is_phr  = rx_byte == sepc_pkg::OP_PHRASE_W;
	wire is_clr  = rx_byte == sepc_pkg::OP_FAULT_CLR;
	wire bank1   = rx_byte[0];

	// Register bus decode
	wire wr_fire = wr_go_q && s_axi_awvalid && s_axi_wvalid;
	wire rd_fire = rd_go_q && s_axi_arvalid;
	wire wr_map  = (s_axi_awaddr & sepc_pkg::ADDR_MAP_MASK) == 8'h00;
	wire rd_map  = (s_axi_araddr & sepc_pkg::ADDR_MAP_MASK) == 8'h00;
	wire wr_rom  = wr_fire && s_axi_awaddr == sepc_pkg::ADDR_ROM_INFO;
	wire wr_en   = wr_fire && s_axi_awaddr == sepc_pkg::ADDR_FAULT_EN;
	wire wr_clr  = wr_fire && s_axi_awaddr == sepc_pkg::ADDR_CLEAR;
	wire clear   = wr_clr || (at_op && is_clr);

	// Fault byte selected by the bank bit
	wire [7:0] flt_byte = bank1 ? flags[15:8] : flags[7:0];

	wire [31:0] rd_mux =
		(s_axi_araddr == sepc_pkg::ADDR_ROM_INFO) ? {24'h0, rom_info_q} :
		(s_axi_araddr == sepc_pkg::ADDR_FAULT_EN) ? {16'h0, fault_en_q} :
		(s_axi_araddr == sepc_pkg::ADDR_FLAGS)    ? {16'h0, flags} :
		(s_axi_araddr == sepc_pkg::ADDR_ROUTE)    ?
			{18'h0, pin_cfg_q[1], 2'h0, pin_cfg_q[0]} :
		(s_axi_araddr == sepc_pkg::ADDR_PHR01)    ?
			{4'h0, phrase_q[1], 4'h0, phrase_q[0]} :
		(s_axi_araddr == sepc_pkg::ADDR_PHR23)    ?
			{4'h0, phrase_q[3], 4'h0, phrase_q[2]} :
		(s_axi_araddr == sepc_pkg::ADDR_CHAN)     ?
			{22'h0, pin_q, chan_busy_n_i, chan_ready_n_i} : 32'h0;

	sepc_fault_flags u_flags (
		.clk_i             (clk_i),
		.rst_i             (rst_i),
		.clear_i           (clear),
		.en_i              (fault_en_q),
		.cmd_error_i       (cmd_error_i),
		.spk_open_i        (spk_open_i),
		.die_temp_i        (die_temp_i),
		.spk_short_i       (spk_short_i),
		.flash_fault_i     (flash_fault_i),
		.wdt_ovf_i         (wdt_ovf_i),
		.rst_cnt_ovf_i     (rst_cnt_ovf_i),
		.osc_stop_i        (osc_stop_i),
		.wave_mismatch_i   (wave_mismatch_i),
		.bit_clk_fault_i   (bit_clk_fault_i),
		.frame_clk_fault_i (frame_clk_fault_i),
		.audio_in_fault_i  (audio_in_fault_i),
		.mix_count_fault_i (mix_count_fault_i),
		.flags_o           (flags),
		.any_o             (any_fault)
	);

	always_comb begin
		st_d = st_q;
		if (link_idle) begin
			st_d = sepc_pkg::CMD_IDLE;
		end else if (rx_valid) begin
			case (st_q)
				sepc_pkg::CMD_IDLE: begin
					if (is_rom || is_flt) begin
						st_d = sepc_pkg::CMD_READ;
					end else if (is_pin) begin
						st_d = sepc_pkg::CMD_PIN_ARG;
					end else if (is_phr) begin
						st_d = sepc_pkg::CMD_PHR_HI;
					end
				end
				sepc_pkg::CMD_PHR_HI: st_d = sepc_pkg::CMD_PHR_LO;
				default: st_d = sepc_pkg::CMD_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q      <= sepc_pkg::CMD_IDLE;
			tx_load_q <= 1'b0;
			tx_byte_q <= 8'h00;
		end else begin
			st_q      <= st_d;
			tx_load_q <= at_op && (is_rom || is_flt);
			if (at_op && is_rom) begin
				tx_byte_q <= rom_info_q;
			end else if (at_op && is_flt) begin
				tx_byte_q <= flt_byte;
			end
		end
	end

	// Status pin routing; each pin owns its configuration
	for (genvar p = 0; p < 2; p++) begin : g_pin
		wire [5:0] cfg = pin_cfg_q[p];
		wire [3:0] msk = cfg[sepc_pkg::ARG_MASK_HI:0];
		wire [3:0] sel = cfg[sepc_pkg::ARG_SRC_LO] ? chan_ready_n_i : chan_busy_n_i;
		// Unselected channels read high so they never pull the pin low
		wire chan_lvl = &(sel | ~msk);
		wire lvl = cfg[sepc_pkg::ARG_SRC_LO + sepc_pkg::SRC_FAULT_BIT] ? any_fault : chan_lvl;
		wire upd = rx_valid && st_q == sepc_pkg::CMD_PIN_ARG &&
			rx_byte[sepc_pkg::ARG_PIN_BIT] == 1'(p);
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				pin_cfg_q[p] <= (p == 0) ? sepc_pkg::PIN_A_RST : sepc_pkg::PIN_B_RST;
				pin_q[p]     <= 1'b1;
			end else begin
				if (upd) begin
					pin_cfg_q[p] <= rx_byte[sepc_pkg::CFG_W-1:0];
				end
				pin_q[p] <= lvl;
			end
		end
	end

	assign state_pin_a_o = pin_q[0];
	assign state_pin_b_o = pin_q[1];

	// Phrase store: no playback is triggered here
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ch_q <= 2'h0;
			hi_q <= 4'h0;
		end else if (rx_valid && st_q == sepc_pkg::CMD_PHR_HI) begin
			ch_q <= rx_byte[sepc_pkg::CH_HI:sepc_pkg::CH_LO];
			hi_q <= rx_byte[sepc_pkg::PHR_HI_W-1:0];
		end
	end

	for (genvar c = 0; c < sepc_pkg::CHANS; c++) begin : g_phr
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				phrase_q[c] <= 12'h000;
			end else if (rx_valid && st_q == sepc_pkg::CMD_PHR_LO && ch_q == 2'(c)) begin
				phrase_q[c] <= {hi_q, rx_byte};
			end
		end
		assign phrase_number_o[c*sepc_pkg::PHR_W +: sepc_pkg::PHR_W] = phrase_q[c];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_any_o <= 1'b0;
			rom_info_q  <= sepc_pkg::ROM_INFO_RST;
			fault_en_q  <= sepc_pkg::FAULT_EN_RST;
		end else begin
			fault_any_o <= any_fault;
			if (wr_rom && s_axi_wstrb[0]) begin
				rom_info_q <= s_axi_wdata[7:0];
			end
			if (wr_en && s_axi_wstrb[0]) begin
				fault_en_q[7:0] <= s_axi_wdata[7:0];
			end
			if (wr_en && s_axi_wstrb[1]) begin
				fault_en_q[15:8] <= s_axi_wdata[15:8] & sepc_pkg::FLAG_MASK[15:8];
			end
		end
	end

	// AXI4-Lite slave: address and data are taken together
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_go_q      <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= sepc_pkg::RESP_OKAY;
			rd_go_q      <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= sepc_pkg::RESP_OKAY;
			s_axi_rdata  <= 32'h0;
		end else begin
			wr_go_q <= s_axi_awvalid && s_axi_wvalid && !wr_go_q && !s_axi_bvalid;
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_map ? sepc_pkg::RESP_OKAY : sepc_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			rd_go_q <= s_axi_arvalid && !rd_go_q && !s_axi_rvalid;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_mux;
				s_axi_rresp  <= rd_map ? sepc_pkg::RESP_OKAY : sepc_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	assign s_axi_awready = wr_go_q;
	assign s_axi_wready  = wr_go_q;
	assign s_axi_arready = rd_go_q;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_rom;
		(at_op && is_rom) |=> tx_load_q && tx_byte_q == $past(rom_info_q);
	endproperty
	a_rom: assert property (p_rom) else $error("ROM info not loaded");

	property p_bank1;
		(at_op && is_flt && bank1) |=> tx_byte_q[3:1] == 3'h0 && tx_byte_q[7:4] == $past(flags[15:12]);
	endproperty
	a_bank1: assert property (p_bank1) else $error("bank 1 byte wrong");

	property p_bank0;
		(at_op && is_flt && !bank1) |=> tx_byte_q == $past(flags[7:0]);
	endproperty
	a_bank0: assert property (p_bank0) else $error("bank 0 byte wrong");

	property p_reset_route;
		$past(rst_i) |-> pin_cfg_q[0] == sepc_pkg::PIN_A_RST && pin_cfg_q[1] == sepc_pkg::PIN_B_RST;
	endproperty
	a_reset_route: assert property (p_reset_route) else $error("bad reset routing");

	property p_keep_other;
		(rx_valid && st_q == sepc_pkg::CMD_PIN_ARG && !rx_byte[sepc_pkg::ARG_PIN_BIT])
			|=> pin_cfg_q[1] == $past(pin_cfg_q[1]) && pin_cfg_q[0] == $past(rx_byte[5:0]);
	endproperty
	a_keep_other: assert property (p_keep_other) else $error("pin routing crossed");

	property p_any_low;
		(pin_cfg_q[0][5:4] == sepc_pkg::SRC_BUSY && (chan_busy_n_i & pin_cfg_q[0][3:0]) != pin_cfg_q[0][3:0])
			|=> !state_pin_a_o;
	endproperty
	a_any_low: assert property (p_any_low) else $error("pin A not low");

	property p_fault_pin;
		(pin_cfg_q[1][5] && any_fault) |=> state_pin_b_o;
	endproperty
	a_fault_pin: assert property (p_fault_pin) else $error("pin B fault missed");

	property p_phrase;
		(rx_valid && st_q == sepc_pkg::CMD_PHR_LO) |=> phrase_q[ch_q] == {hi_q, $past(rx_byte)};
	endproperty
	a_phrase: assert property (p_phrase) else $error("phrase not stored");
endmodule

// [sepc_host_model.sv]
/*
 Host model for the serial command link: framed bytes, MSB first.
 Assumes the device samples si on sck rise and drives so after sck fall.
*/
`timescale 1ns/10ps
module sepc_host_model (
	input  wire logic so_i,
	input  wire logic so_oe_i,
	output logic      sck_o,
	output logic      cs_n_o,
	output logic      si_o
);
	initial begin
		sck_o = 1'b1;
		cs_n_o = 1'b1;
		si_o = 1'b0;
	end
	// Link clock stands still outside frames
	task automatic frame(input logic on);
		#400;
		cs_n_o = ~on;
		#400;
	endtask
	// Answer bits count only while the device drives the line
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			#400 sck_o = 1'b0;
			si_o = tx[i];
			#400 sck_o = 1'b1;
			rx[i] = so_i & so_oe_i;
		end
		#800 si_o = ~si_o;
	endtask
endmodule

// [sepc_cmd_core_tb.sv]
/*
 Self-checking bench for the command interpreter, AXI4-Lite master inside.
 Assumes the host model on the link and a 100 ns clock.
*/
`timescale 1ns/10ps
module sepc_cmd_core_tb;
	logic        clk_i, rst_i, sck, cs_n, si, so, so_oe, pa, pb, fa;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [3:0]  rdy_n, bsy_n;
	logic [11:0] flt;
	logic [7:0]  temp, awaddr, araddr, rx;
	logic [47:0] phr, exp_phr;
	logic [31:0] wdata, rdata, seed, v;
	logic [1:0]  bresp, rresp, rr;
	logic [5:0]  cfg [2];
	int          mismatches, checks;
	localparam int POS [12] = '{0, 1, 3, 4, 5, 6, 7, 8, 12, 13, 14, 15};

	sepc_host_model host_u (.so_i(so), .so_oe_i(so_oe), .sck_o(sck), .cs_n_o(cs_n), .si_o(si));
	sepc_cmd_core dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .so_o(so),
		.so_oe_o(so_oe), .chan_ready_n_i(rdy_n), .chan_busy_n_i(bsy_n), .cmd_error_i(flt[0]),
		.spk_open_i(flt[1]), .die_temp_i(temp), .spk_short_i(flt[2]), .flash_fault_i(flt[3]),
		.wdt_ovf_i(flt[4]), .rst_cnt_ovf_i(flt[5]), .osc_stop_i(flt[6]),
		.wave_mismatch_i(flt[7]), .bit_clk_fault_i(flt[8]), .frame_clk_fault_i(flt[9]),
		.audio_in_fault_i(flt[10]), .mix_count_fault_i(flt[11]), .state_pin_a_o(pa),
		.state_pin_b_o(pb), .fault_any_o(fa), .phrase_number_o(phr), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
	);

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic pin_exp(input logic [5:0] c);
		logic [3:0] s;
		s = c[4] ? rdy_n : bsy_n;
		return c[5] ? 1'b0 : &(s | ~c[3:0]);
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic close_out();
		if (mismatches == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do @(posedge clk_i); while (awready !== 1'b1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		bready <= 1'b1;
		do @(posedge clk_i); while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk_i); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge clk_i); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic send(input logic [23:0] b, input int n);
		// Keep link edges away from the system clock edge
		#10;
		host_u.frame(1'b1);
		for (int k = n - 1; k >= 0; k--) host_u.xfer(b[8*k+:8], rx);
		host_u.frame(1'b0);
	endtask
	// Answer byte is clocked out with si held low
	task automatic rd_flags(input logic bank);
		send({8'h00, 7'h5C, bank, 8'h00}, 2);
		if (pb === 1'b1 && rx === 8'h00) send({8'h00, 7'h5C, bank, 8'h00}, 2);
	endtask

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	initial begin
		#3000000;
		mismatches++;
		close_out();
	end
	initial begin
		seed = 32'h000041E0;
		{rst_i, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
		{awaddr, araddr, wdata, flt, temp} = '0;
		rdy_n = 4'hA;
		bsy_n = 4'h5;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk(pa, 1'b0);
		chk(pb, 1'b1);
		axi_rd(8'h10, v, rr);
		chk(v, 32'h00000111);
		cfg[0] = 6'h11;
		cfg[1] = 6'h01;
		repeat (12) begin
			@(posedge clk_i);
			v = rnd();
			rdy_n <= v[11:8];
			bsy_n <= v[15:12];
			flt <= v[27:16] & 12'hFEF;
			temp <= v[31:24];
			cfg[v[6]] = v[5:0];
			send({8'h00, 8'hC0, 1'b0, v[6:0]}, 2);
			@(posedge clk_i);
			chk(pa, pin_exp(cfg[0]));
			chk(pb, pin_exp(cfg[1]));
			axi_rd(8'h10, v, rr);
			chk(v, {18'h0, cfg[1], 2'h0, cfg[0]});
			axi_rd(8'h1C, v, rr);
			chk(v, {22'h0, pb, pa, bsy_n, rdy_n});
		end
		@(posedge clk_i);
		flt <= '0;
		temp <= '0;
		rdy_n <= 4'h0;
		v = rnd();
		axi_wr(8'h00, {24'h0, v[7:0]});
		send({16'h00B4, 8'h00}, 2);
		chk(rx, v[7:0]);
		axi_rd(8'h20, v, rr);
		chk({30'h0, rr}, 32'h2);
		chk(v, 32'h0);
		axi_wr(8'h24, 32'h0);
		chk({30'h0, bresp}, 32'h2);
		rdy_n <= 4'hF;
		exp_phr = '0;
		for (int c = 0; c < 4; c++) begin
			v = rnd();
			// Top channel gets a phrase beyond the short command's reach
			if (c == 3) v[11:0] = 12'hFFF;
			exp_phr[12*c+:12] = v[11:0];
			send({8'hC4, 2'b00, c[1:0], v[11:0]}, 3);
			@(posedge clk_i);
			chk(phr[31:0], exp_phr[31:0]);
			chk(phr[47:32], exp_phr[47:32]);
		end
		axi_wr(8'h04, 32'h0000F1FF);
		chk({30'h0, bresp}, 32'h0);
		send({16'h00C0, 8'h60}, 2);
		for (int i = 0; i < 12; i++) begin
			@(posedge clk_i);
			flt <= 12'h001 << i;
			@(posedge clk_i);
			flt <= '0;
			rd_flags(POS[i] >= 8);
			chk(rx, 8'h01 << POS[i][2:0]);
			chk(pb, 1'b1);
			chk(fa, 1'b1);
			axi_wr(8'h0C, 32'h0);
		end
		@(posedge clk_i);
		flt <= 12'h010;
		@(posedge clk_i);
		flt <= '0;
		rd_flags(1'b0);
		chk(rx, 8'h60);
		axi_wr(8'h0C, 32'h0);
		@(posedge clk_i);
		temp <= 8'h81;
		rd_flags(1'b0);
		chk(rx, 8'h00);
		@(posedge clk_i);
		temp <= 8'h82;
		rd_flags(1'b0);
		chk(rx, 8'h04);
		axi_wr(8'h0C, 32'h0);
		rd_flags(1'b0);
		chk(rx, 8'h04);
		@(posedge clk_i);
		temp <= 8'h00;
		send(24'h0000FF, 1);
		repeat (3) @(posedge clk_i);
		chk(pb, 1'b0);
		chk(fa, 1'b0);
		close_out();
	end
endmodule
